// ==== rtl/radio_port_pkg.sv ====
// Package: constants, enums and structs for the radio host serial port
package radio_port_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned BAUD = 115_200;
   localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
   localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
   localparam int unsigned FIFO_DEPTH = 4;
   localparam int unsigned DATA_W = 8;
   // Command bytes, reset values and error reply
   localparam logic [7:0] CMD_WR_MASK = 8'h01;
   localparam logic [7:0] CMD_RD_MASK = 8'h02;
   localparam logic [7:0] CMD_RD_CAUSE = 8'h03;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] CAUSE_RESET = 8'h00;
   localparam logic [7:0] REPLY_ERR = 8'hff;
   typedef enum logic [1:0] {
      CMD_IDLE,
      CMD_ARG
   } cmd_state_e;
   typedef struct packed {
      logic is_data;
      logic [7:0] data;
   } tx_word_s;
endpackage : radio_port_pkg

// ==== rtl/sync_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   wire do_wr = in_valid && in_ready;
   wire do_rd = out_valid && out_ready;
   assign in_ready = (count_ff != (AW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data = mem[rd_ptr_ff];
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (do_wr) wr_ptr_ff <= AW'((wr_ptr_ff + 1'b1) % DEPTH);
         if (do_rd) rd_ptr_ff <= AW'((rd_ptr_ff + 1'b1) % DEPTH);
         count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule : sync_fifo
`default_nettype wire

// ==== rtl/radio_host_port.sv ====
// Host serial port of the radio module: receiver, command decoder, FIFO, transmitter
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - One serial input carries commands and payload
// R2 - Serial output carries replies and air data
// R3 - Clear-to-send low when ready, high busy
// R4 - Host stops sending while clear-to-send high
// R5 - Host sets command-select low for commands
// R6 - Byte meaning follows sampled command-select level
// R7 - Enabled exception drives exception output high
// R8 - Reading cause register lowers exception output
// R9 - Response indicator low for replies, high data
// R10 - Buffer empty high when nothing pending
// R11 - All settings reached only over serial
// R12 - Radio handled internally, link looks transparent
// R13 - Frame: start, 8 data LSB first, stop
// R14 - Mask and cause reached by serial commands
module radio_host_port
   import radio_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serial_rx,
   output logic serial_tx,
   output logic clear_to_send_n,
   input wire logic command_select_n,
   output logic exception_flag_out,
   output logic response_indicator,
   output logic input_buffer_empty,
   // Radio side: payload to air and data from air
   output logic air_tx_valid,
   output logic [7:0] air_tx_data,
   input wire logic air_tx_ready,
   input wire logic air_rx_valid,
   input wire logic [7:0] air_rx_data,
   input wire logic [7:0] exception_events
);
   function automatic logic bit_done(input logic [15:0] cnt);
      return cnt == 16'(BIT_CYCLES - 1);
   endfunction : bit_done

   // Receiver
   logic [15:0] rx_cnt_ff;
   logic [3:0] rx_bit_ff;
   logic [7:0] rx_shift_ff;
   logic rx_busy_ff;
   logic rx_strobe_ff;
   logic rx_is_cmd_ff;
   wire rx_start = !rx_busy_ff && !serial_rx;
   wire rx_tick = rx_busy_ff && bit_done(rx_cnt_ff);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt_ff <= '0;
         rx_bit_ff <= '0;
         rx_shift_ff <= '0;
         rx_busy_ff <= 1'b0;
         rx_strobe_ff <= 1'b0;
         rx_is_cmd_ff <= 1'b0;
      end else begin
         rx_strobe_ff <= 1'b0;
         if (rx_start) begin // R1
            rx_busy_ff <= 1'b1;
            rx_bit_ff <= '0;
            rx_cnt_ff <= 16'(HALF_CYCLES);
         end else if (rx_tick) begin // R13
            rx_cnt_ff <= '0;
            rx_bit_ff <= rx_bit_ff + 4'd1;
            if (rx_bit_ff >= 4'd1 && rx_bit_ff <= 4'd8) begin
               rx_shift_ff <= {serial_rx, rx_shift_ff[7:1]};
            end
            if (rx_bit_ff == 4'd9) begin
               rx_busy_ff <= 1'b0;
               rx_strobe_ff <= serial_rx;
               rx_is_cmd_ff <= !command_select_n; // R6
            end
         end else if (rx_busy_ff) begin
            rx_cnt_ff <= rx_cnt_ff + 16'd1;
         end
      end
   end

   // Command decoder and exception logic
   cmd_state_e cmd_state_ff;
   logic [7:0] exc_mask_ff;
   logic [7:0] exception_cause_register_ff;
   logic exc_out_ff;
   logic reply_valid_ff;
   logic [7:0] reply_data_ff;
   wire rx_cmd = rx_strobe_ff && rx_is_cmd_ff; // R11
   wire rx_payload = rx_strobe_ff && !rx_is_cmd_ff;
   wire cause_read = rx_cmd && cmd_state_ff == CMD_IDLE && rx_shift_ff == CMD_RD_CAUSE;
   wire [7:0] masked_evt = exception_events & exc_mask_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_state_ff <= CMD_IDLE;
         exc_mask_ff <= MASK_RESET;
         reply_valid_ff <= 1'b0;
         reply_data_ff <= '0;
      end else begin
         reply_valid_ff <= 1'b0;
         if (rx_cmd) begin // R14
            case (cmd_state_ff)
               CMD_IDLE: begin
                  if (rx_shift_ff == CMD_WR_MASK) begin
                     cmd_state_ff <= CMD_ARG;
                  end else begin
                     reply_valid_ff <= 1'b1;
                     reply_data_ff <= (rx_shift_ff == CMD_RD_MASK) ? exc_mask_ff :
                        (rx_shift_ff == CMD_RD_CAUSE) ? exception_cause_register_ff :
                        REPLY_ERR;
                  end
               end
               CMD_ARG: begin
                  exc_mask_ff <= rx_shift_ff;
                  reply_valid_ff <= 1'b1;
                  reply_data_ff <= rx_shift_ff;
                  cmd_state_ff <= CMD_IDLE;
               end
               default: cmd_state_ff <= CMD_IDLE;
            endcase
         end
      end
   end
   // Events set wins over the read clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         exception_cause_register_ff <= CAUSE_RESET;
         exc_out_ff <= 1'b0;
      end else begin
         exception_cause_register_ff <= (cause_read ? 8'h00 : exception_cause_register_ff)
            | masked_evt;
         if (masked_evt != 8'h00) begin
            exc_out_ff <= 1'b1; // R7
         end else if (cause_read) begin
            exc_out_ff <= 1'b0; // R8
         end
      end
   end

   // Payload buffer toward the radio
   logic pay_in_ready;
   logic pay_out_valid;
   logic [7:0] pay_out_data;
   logic pay_out_ready;
   logic buf_drained;
   // Output register refills when empty or when the radio takes its byte
   assign pay_out_ready = !air_tx_valid || air_tx_ready; // R12
   assign buf_drained = !pay_out_valid && !air_tx_valid;
   sync_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_pay_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(rx_payload),
      .in_ready(pay_in_ready),
      .in_data(rx_shift_ff),
      .out_valid(pay_out_valid),
      .out_ready(pay_out_ready),
      .out_data(pay_out_data)
   );
   // Radio consumes a byte when valid and ready are both high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         air_tx_valid <= 1'b0;
         air_tx_data <= '0;
         clear_to_send_n <= 1'b1;
         input_buffer_empty <= 1'b1;
      end else begin
         if (pay_out_ready) begin // R12
            air_tx_valid <= pay_out_valid;
            air_tx_data <= pay_out_data;
         end
         clear_to_send_n <= !pay_in_ready || rx_payload; // R3 R4
         input_buffer_empty <= buf_drained && !rx_busy_ff && !rx_payload; // R10
      end
   end

   // Transmitter: replies take priority over air data
   logic [15:0] tx_cnt_ff;
   logic [3:0] tx_bit_ff;
   logic [9:0] tx_shift_ff;
   logic tx_busy_ff;
   logic pend_valid_ff;
   tx_word_s pend_ff;
   wire tx_tick = tx_busy_ff && bit_done(tx_cnt_ff);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_valid_ff <= 1'b0;
         pend_ff <= '0;
         tx_cnt_ff <= '0;
         tx_bit_ff <= '0;
         tx_shift_ff <= '1;
         tx_busy_ff <= 1'b0;
         serial_tx <= 1'b1;
         response_indicator <= 1'b1;
      end else begin
         if (reply_valid_ff) begin
            pend_valid_ff <= 1'b1;
            pend_ff <= '{is_data: 1'b0, data: reply_data_ff};
         end else if (air_rx_valid && !pend_valid_ff) begin
            pend_valid_ff <= 1'b1;
            pend_ff <= '{is_data: 1'b1, data: air_rx_data};
         end
         if (!tx_busy_ff && pend_valid_ff && !reply_valid_ff) begin // R2
            tx_busy_ff <= 1'b1;
            tx_cnt_ff <= '0;
            tx_bit_ff <= '0;
            tx_shift_ff <= {1'b1, pend_ff.data, 1'b0}; // R13
            response_indicator <= pend_ff.is_data; // R9
            pend_valid_ff <= 1'b0;
            serial_tx <= 1'b0;
         end else if (tx_tick) begin
            tx_cnt_ff <= '0;
            tx_bit_ff <= tx_bit_ff + 4'd1;
            tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
            serial_tx <= tx_shift_ff[1];
            if (tx_bit_ff == 4'd9) begin
               tx_busy_ff <= 1'b0;
               serial_tx <= 1'b1;
            end
         end else if (tx_busy_ff) begin
            tx_cnt_ff <= tx_cnt_ff + 16'd1;
         end
      end
   end
   assign exception_flag_out = exc_out_ff;
endmodule : radio_host_port
`default_nettype wire

// ==== sim/radio_host_port_chk.sv ====
// Checker for the radio host serial port
`timescale 1ns/1ps
`default_nettype none
module radio_host_port_chk
   import radio_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serial_rx,
   input wire logic serial_tx,
   input wire logic clear_to_send_n,
   input wire logic command_select_n,
   input wire logic exception_flag_out,
   input wire logic response_indicator,
   input wire logic input_buffer_empty,
   input wire logic air_tx_valid,
   input wire logic [7:0] air_tx_data,
   input wire logic air_tx_ready,
   input wire logic air_rx_valid,
   input wire logic [7:0] air_rx_data,
   input wire logic [7:0] exception_events
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   start_low_a: assert property ($fell(serial_tx) |-> !serial_tx [*8])
      else $error("start bit too short");
   start_hold_a: assert property ($fell(serial_tx) |-> ##300 !serial_tx)
      else $error("start bit ends early");
   ri_frame_a: assert property ($changed(response_indicator) |-> $fell(serial_tx))
      else $error("indicator moved outside frame start");
   flag_cause_a: assert property ($rose(exception_flag_out) |->
      $past(exception_events) != 8'h00 || $past(exception_events, 2) != 8'h00)
      else $error("flag rose without event");
   flag_clear_a: assert property ($fell(exception_flag_out) |->
      ##[0:5] !serial_tx && !response_indicator)
      else $error("flag fell without reply");
   hold_data_a: assert property (air_tx_valid && !air_tx_ready |=>
      air_tx_valid && $stable(air_tx_data))
      else $error("payload dropped while stalled");
   busy_empty_a: assert property ($fell(serial_rx) |-> ##[1:3] !input_buffer_empty)
      else $error("empty high during receive");
   valid_empty_a: assert property ($rose(air_tx_valid) |-> !input_buffer_empty)
      else $error("empty high with payload");
   cover property ($fell(exception_flag_out));
   cover property (air_tx_valid && air_tx_ready);
   cover property ($rose(response_indicator));
endmodule : radio_host_port_chk
bind radio_host_port radio_host_port_chk i_chk (.clk(clk), .rst_n(rst_n),
   .serial_rx(serial_rx), .serial_tx(serial_tx), .clear_to_send_n(clear_to_send_n),
   .command_select_n(command_select_n), .exception_flag_out(exception_flag_out),
   .response_indicator(response_indicator), .input_buffer_empty(input_buffer_empty),
   .air_tx_valid(air_tx_valid), .air_tx_data(air_tx_data), .air_tx_ready(air_tx_ready),
   .air_rx_valid(air_rx_valid), .air_rx_data(air_rx_data),
   .exception_events(exception_events));
`default_nettype wire

// ==== sim/host_model.sv ====
// Host microcontroller model: sends frames, captures replies
`timescale 1ns/1ps
`default_nettype none
module host_model
   import radio_port_pkg::*;
(
   input wire logic clk,
   input wire logic serial_tx,
   input wire logic clear_to_send_n,
   input wire logic response_indicator,
   output logic serial_rx,
   output logic command_select_n,
   output logic [7:0] got,
   output logic got_ri,
   output int got_cnt
);
   initial begin
      serial_rx = 1'b1;
      command_select_n = 1'b1;
      got_cnt = 0;
   end
   task automatic send(input logic sel_n, input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      while (clear_to_send_n !== 1'b0) @(negedge clk);
      command_select_n = sel_n;
      for (int i = 0; i < 10; i++) begin
         serial_rx = f[i];
         repeat (BIT_CYCLES) @(negedge clk);
      end
   endtask : send
   always @(negedge serial_tx) begin
      repeat (HALF_CYCLES) @(posedge clk);
      got_ri = response_indicator;
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES) @(posedge clk);
         got[i] = serial_tx;
      end
      repeat (BIT_CYCLES) @(posedge clk);
      got_cnt++;
   end
endmodule : host_model
`default_nettype wire

// ==== sim/radio_host_port_bench.sv ====
// Testbench for the radio host serial port
`timescale 1ns/1ps
`default_nettype none
module radio_host_port_bench;
   import radio_port_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, atr = 1'b0, arv = 1'b0;
   logic [7:0] ard = 8'h00, ev = 8'h00, atd, got;
   logic srx, stx, cts_n, csn, flag, ri, empty, atv, got_ri;
   int got_cnt, bad_count = 0, checks = 0, cyc = 0;
   radio_host_port i_dut (.clk(clk), .rst_n(rst_n), .serial_rx(srx), .serial_tx(stx),
      .clear_to_send_n(cts_n), .command_select_n(csn), .exception_flag_out(flag),
      .response_indicator(ri), .input_buffer_empty(empty), .air_tx_valid(atv),
      .air_tx_data(atd), .air_tx_ready(atr), .air_rx_valid(arv), .air_rx_data(ard),
      .exception_events(ev));
   host_model i_host (.clk(clk), .serial_tx(stx), .clear_to_send_n(cts_n),
      .response_indicator(ri), .serial_rx(srx), .command_select_n(csn), .got(got),
      .got_ri(got_ri), .got_cnt(got_cnt));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic summarize();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task automatic wait_rx(input int n);
      while (got_cnt < n) @(negedge clk);
   endtask : wait_rx
   task automatic pulse(input logic [7:0] e);
      ev = e;
      @(negedge clk);
      ev = 8'h00;
      repeat (4) @(negedge clk);
   endtask : pulse
   task automatic t_mask();
      i_host.send(1'b0, CMD_WR_MASK);
      i_host.send(1'b0, 8'h04);
      wait_rx(1);
      cmp(got, 8'h04);
      cmp({7'h00, got_ri}, 8'h00);
   endtask : t_mask
   task automatic t_event();
      pulse(8'h08);
      cmp({7'h00, flag}, 8'h00);
      pulse(8'h04);
      cmp({7'h00, flag}, 8'h01);
      i_host.send(1'b0, CMD_RD_CAUSE);
      wait_rx(2);
      cmp(got, 8'h04);
      cmp({7'h00, flag}, 8'h00);
   endtask : t_event
   task automatic t_payload();
      i_host.send(1'b1, 8'ha5);
      for (int i = 0; i < 50 && atv !== 1'b1; i++) @(negedge clk);
      repeat (5) @(negedge clk);
      cmp(atd, 8'ha5);
      cmp({7'h00, empty}, 8'h00);
      atr = 1'b1;
      @(negedge clk);
      atr = 1'b0;
      repeat (5) @(negedge clk);
      cmp({7'h00, empty}, 8'h01);
   endtask : t_payload
   task automatic t_air();
      ard = 8'h3c;
      arv = 1'b1;
      while (stx !== 1'b0) @(negedge clk);
      arv = 1'b0;
      wait_rx(3);
      cmp(got, 8'h3c);
      cmp({7'h00, got_ri}, 8'h01);
   endtask : t_air
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      cmp({3'h0, flag, ri, empty, cts_n, stx}, 8'h0d);
      t_mask();
      t_event();
      t_payload();
      t_air();
      summarize();
   end
endmodule : radio_host_port_bench
`default_nettype wire
